//--- sfsp_pkg.sv
// Constants, phase type and protection helpers for the serial flash port
package sfsp_pkg;

  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;

  // Status register layout
  localparam int BUSY_BIT = 0;
  localparam int WEL_BIT = 1;
  localparam int PROT_LO = 2;
  localparam int PROT_HI = 4;
  localparam int BOTTOM_BIT = 5;
  localparam int RSVD_BIT = 6;
  localparam int LOCK_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] STATUS_WR_MASK = 8'hbc;

  // Array geometry
  localparam int PAGE_COUNT = 2048;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam int SECTOR_COUNT = 128;
  localparam int SECTOR_LSB = 12;
  localparam logic [3:0] BLOCK_COUNT = 4'h8;
  localparam int BLOCK_LSB = 16;
  localparam int ADDR_MSB = 18;

  // Serial framing
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] ADDR_LAST = 2'h2;

  // Pin vector positions and idle levels
  localparam int PIN_SCK = 0;
  localparam int PIN_SI = 1;
  localparam int PIN_CS = 2;
  localparam int PIN_WP = 3;
  localparam int PIN_HOLD = 4;
  localparam logic [4:0] PIN_IDLE = 5'h1c;

  typedef enum logic [4:0] {
    PH_CMD = 5'h01,
    PH_ADDR = 5'h02,
    PH_DATA = 5'h04,
    PH_READ = 5'h08,
    PH_SKIP = 5'h10
  } sfsp_phase_e;

  // Blocks covered by each protection level
  function automatic logic [3:0] sfsp_prot_count(input logic [2:0] lvl);
    logic [3:0] n;
    n = 4'h8;
    case (lvl)
      3'h0: n = 4'h0;
      3'h1: n = 4'h1;
      3'h2: n = 4'h2;
      3'h3: n = 4'h4;
      3'h5: n = 4'h6;
      3'h6: n = 4'h7;
      default: n = 4'h8;
    endcase
    return n;
  endfunction : sfsp_prot_count

  function automatic logic sfsp_block_prot(input logic [2:0] blk,
      input logic [2:0] lvl, input logic bottom);
    logic [3:0] n;
    n = sfsp_prot_count(lvl);
    if (bottom) begin
      return {1'b0, blk} < n;
    end
    return {1'b0, blk} >= (BLOCK_COUNT - n);
  endfunction : sfsp_block_prot

endpackage : sfsp_pkg

//--- sfsp_flash_port.sv
// Serial port, status register and write protection of the flash device
//
// Behaviour
// - Input bits are taken on each rising serial clock edge.
// - Output bit changes only on falling serial clock edges.
// - Port acts only while chip select is low.
// - Pause input freezes the exchange without reset; resumes later.
// - Works in SPI mode 0 and mode 3.
// - 2048 pages of 256 bytes; program takes 1 to 256 bytes.
// - 128 sectors of 4K bytes and 8 blocks of 64K bytes.
// - Erasing one sector or block leaves all others untouched.
// - Erase only by sector, block or whole array; no page erase.
// - Bit 0 is read-only busy flag, zero at power-up.
// - Bit 1 is read-only write-enable latch, zero at power-up.
// - Only protection level, bottom select and lock bits take writes.
// - Bit 5 selects which array end is protected, default 0.
// - Bit 6 is reserved and reads zero.
// - Lock bit set makes level and bottom bits read-only.
// - Level, bottom and lock bits are held as volatile state; reset clears them.
// - Whole array unprotected at power-on, level bits zero.
// - Write-protect pin enables or disables the lock bit's effect.
// - Pin low with lock set refuses changes; pin high ignores lock.
// - Write-enable latch clears at power-up and after write operations.
// - Opcode, address and data shift MSB first in 8-bit cycles.
// - Bottom bit 0 protects from top, 1 protects from bottom.
`timescale 1ns/1ns
`default_nettype none

module sfsp_flash_port #(
  parameter logic [23:0] PROG_CYCLES = 24'h000040,
  parameter logic [23:0] SECTOR_CYCLES = 24'h000080,
  parameter logic [23:0] BLOCK_CYCLES = 24'h000100,
  parameter logic [23:0] CHIP_CYCLES = 24'h000200
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_cs_n,
  input wire logic i_wp_n,
  input wire logic i_hold_n,
  output logic o_so,
  output logic o_so_oe
);

  // Pin sampling: three stages, change accepted when stages two and three agree
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic [4:0] pin_s3;
  logic [4:0] pin_f;
  wire [4:0] pin_raw = {i_hold_n, i_wp_n, i_cs_n, i_si, i_sck};
  wire [4:0] pin_agree = ~(pin_s2 ^ pin_s3);
  wire [4:0] next_pin_f = (pin_agree & pin_s3) | (~pin_agree & pin_f);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1 <= sfsp_pkg::PIN_IDLE;
      pin_s2 <= sfsp_pkg::PIN_IDLE;
      pin_s3 <= sfsp_pkg::PIN_IDLE;
      pin_f <= sfsp_pkg::PIN_IDLE;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= next_pin_f;
    end
  end

  wire sck_f = pin_f[sfsp_pkg::PIN_SCK];
  wire si_f = pin_f[sfsp_pkg::PIN_SI];
  wire cs_f = pin_f[sfsp_pkg::PIN_CS];
  wire wp_f = pin_f[sfsp_pkg::PIN_WP];
  wire hold_f = pin_f[sfsp_pkg::PIN_HOLD];

  logic sck_p;
  logic cs_p;
  logic held;
  // pause entry/exit
  // Pause changes only while the clock sits low; chip select high drops it
  wire next_held = cs_f ? 1'b0 : (sck_f ? held : ~hold_f);
  wire active = ~cs_f & ~held;
  // mode 0 and 3
  // Edge detection makes the idle clock level irrelevant
  wire sck_rise = active & sck_f & ~sck_p;
  wire sck_fall = active & ~sck_f & sck_p;
  wire cs_rise = cs_f & ~cs_p;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sck_p <= 1'b0;
      cs_p <= 1'b1;
      held <= 1'b0;
    end else begin
      sck_p <= sck_f;
      cs_p <= cs_f;
      held <= next_held;
    end
  end

  // Shifter and framing
  sfsp_pkg::sfsp_phase_e phase;
  sfsp_pkg::sfsp_phase_e next_phase;
  logic [7:0] in_sr;
  logic [2:0] bit_cnt;
  logic [7:0] opcode;
  logic [1:0] addr_cnt;
  logic [23:0] addr;
  logic [8:0] data_cnt;
  logic [7:0] wr_byte;
  logic [2:0] out_idx;
  wire [7:0] next_sr = {in_sr[6:0], si_f};
  wire byte_done = sck_rise & (bit_cnt == sfsp_pkg::BIT_LAST);

  // Status register
  logic busy;
  logic write_enable_latch;
  logic [2:0] prot_lvl;
  logic from_bottom;
  logic bits_lock;
  logic [23:0] busy_cnt;
  wire [7:0] status_rd = {bits_lock, 1'b0, from_bottom, prot_lvl, write_enable_latch, busy};

  // busy filter
  // While busy only a status read is decoded; anything else is skipped
  wire op_is_read = next_sr == sfsp_pkg::OP_STATUS_READ;
  wire op_has_addr = (next_sr == sfsp_pkg::OP_PAGE_PROGRAM) |
      (next_sr == sfsp_pkg::OP_SECTOR_ERASE) |
      (next_sr == sfsp_pkg::OP_BLOCK_ERASE);
  wire op_has_data = next_sr == sfsp_pkg::STATUS_WRITE_CMD;

  always_comb begin
    next_phase = phase;
    if (byte_done) begin
      unique case (phase)
        sfsp_pkg::PH_CMD: begin
          if (op_is_read) next_phase = sfsp_pkg::PH_READ;
          else if (busy) next_phase = sfsp_pkg::PH_SKIP;
          else if (op_has_addr) next_phase = sfsp_pkg::PH_ADDR;
          else if (op_has_data) next_phase = sfsp_pkg::PH_DATA;
          else next_phase = sfsp_pkg::PH_SKIP;
        end
        sfsp_pkg::PH_ADDR: begin
          if (addr_cnt == sfsp_pkg::ADDR_LAST) next_phase = sfsp_pkg::PH_DATA;
        end
        sfsp_pkg::PH_DATA: next_phase = sfsp_pkg::PH_DATA;
        sfsp_pkg::PH_READ: next_phase = sfsp_pkg::PH_READ;
        sfsp_pkg::PH_SKIP: next_phase = sfsp_pkg::PH_SKIP;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase <= sfsp_pkg::PH_CMD;
      in_sr <= 8'h00;
      bit_cnt <= 3'h0;
    end else if (cs_f) begin
      phase <= sfsp_pkg::PH_CMD;
      bit_cnt <= 3'h0;
    end else if (sck_rise) begin
      phase <= next_phase;
      in_sr <= next_sr;
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  wire in_data = phase == sfsp_pkg::PH_DATA;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      opcode <= 8'h00;
      addr_cnt <= 2'h0;
      addr <= 24'h000000;
      data_cnt <= 9'h000;
      wr_byte <= 8'h00;
    end else if (cs_rise) begin
      // Cleared so an empty frame cannot replay the last command
      opcode <= 8'h00;
      addr_cnt <= 2'h0;
      data_cnt <= 9'h000;
    end else if (byte_done) begin
      if (phase == sfsp_pkg::PH_CMD) opcode <= busy ? 8'h00 : next_sr;
      if (phase == sfsp_pkg::PH_ADDR) begin
        addr <= {addr[15:0], next_sr};
        addr_cnt <= addr_cnt + 2'h1;
      end
      if (in_data && data_cnt == 9'h000) wr_byte <= next_sr;
      // page byte count
      // Bytes past a full page wrap in the page; the count saturates
      if (in_data && data_cnt != sfsp_pkg::PAGE_BYTES) begin
        data_cnt <= data_cnt + 9'h001;
      end
    end
  end

  // Command execution on chip select release at a byte boundary
  wire exec = cs_rise & (bit_cnt == 3'h0) & ~busy;
  wire [2:0] tgt_block = addr[sfsp_pkg::ADDR_MSB:sfsp_pkg::BLOCK_LSB];
  wire tgt_prot = sfsp_pkg::sfsp_block_prot(tgt_block, prot_lvl, from_bottom);
  wire exec_wren = exec & (opcode == sfsp_pkg::OP_WRITE_ENABLE);
  wire exec_wrdi = exec & (opcode == sfsp_pkg::OP_WRITE_DISABLE);
  wire exec_status_write_cmd = exec & write_enable_latch & in_data & (data_cnt != 9'h000) &
      (opcode == sfsp_pkg::STATUS_WRITE_CMD);
  wire exec_pp = exec & write_enable_latch & in_data & (data_cnt != 9'h000) &
      (opcode == sfsp_pkg::OP_PAGE_PROGRAM);
  // sector and block size
  // Sector and block erase need the full address; there is no page erase
  wire exec_se = exec & write_enable_latch & in_data & (opcode == sfsp_pkg::OP_SECTOR_ERASE);
  wire exec_be = exec & write_enable_latch & in_data & (opcode == sfsp_pkg::OP_BLOCK_ERASE);
  wire exec_ce = exec & write_enable_latch & (opcode == sfsp_pkg::OP_CHIP_ERASE);
  // Chip erase only when nothing is protected
  wire ce_ok = prot_lvl == 3'h0;
  wire arr_start = ((exec_pp | exec_se | exec_be) & ~tgt_prot) |
      (exec_ce & ce_ok);
  wire arr_refused = ((exec_pp | exec_se | exec_be) & tgt_prot) |
      (exec_ce & ~ce_ok);
  wire [23:0] start_cycles = exec_pp ? PROG_CYCLES :
      exec_se ? SECTOR_CYCLES : exec_be ? BLOCK_CYCLES : CHIP_CYCLES;
  wire busy_last = busy & (busy_cnt == 24'h000001);
  wire lock_on = bits_lock & ~wp_f;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy <= 1'b0;
      busy_cnt <= 24'h000000;
    end else if (arr_start) begin
      busy <= 1'b1;
      busy_cnt <= start_cycles;
    end else if (busy) begin
      busy <= ~busy_last;
      busy_cnt <= busy_cnt - 24'h000001;
    end
  end

  // automatic clear
  // Refused array writes drop the latch at once; accepted ones at completion
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      write_enable_latch <= 1'b0;
    end else if (exec_wrdi | exec_status_write_cmd | arr_refused | busy_last) begin
      write_enable_latch <= 1'b0;
    end else if (exec_wren) begin
      write_enable_latch <= 1'b1;
    end
  end

  // protection state
  // Reset stands for power-on; the bits are otherwise only changed by writes
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prot_lvl <= 3'h0;
      from_bottom <= 1'b0;
      bits_lock <= 1'b0;
    end else if (exec_status_write_cmd && !lock_on) begin
      prot_lvl <= wr_byte[sfsp_pkg::PROT_HI:sfsp_pkg::PROT_LO];
      from_bottom <= wr_byte[sfsp_pkg::BOTTOM_BIT];
      bits_lock <= wr_byte[sfsp_pkg::LOCK_BIT];
    end
  end

  // falling edge output
  // Status repeats for as long as the host keeps clocking
  wire in_read = phase == sfsp_pkg::PH_READ;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
      out_idx <= sfsp_pkg::BIT_LAST;
    end else begin
      o_so_oe <= active & in_read;
      if (cs_f) begin
        out_idx <= sfsp_pkg::BIT_LAST;
      end else if (sck_fall && in_read) begin
        o_so <= status_rd[out_idx];
        out_idx <= out_idx - 3'h1;
      end
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  so_on_fall_a: assert property ($changed(o_so) |-> $past(sck_fall))
    else $error("Serial output changed without a falling clock");
  idle_quiet_a: assert property (cs_f |=> !o_so_oe)
    else $error("Output driven while deselected");
  hold_freeze_a: assert property (held && $past(held) |-> $stable(bit_cnt))
    else $error("Bit count moved during pause");
  bit_count_a: assert property (sck_rise && !cs_f |=>
      bit_cnt == $past(bit_cnt) + 3'h1)
    else $error("Rising edge not counted");
  lock_refuse_a: assert property (exec_status_write_cmd && lock_on |=>
      $stable({bits_lock, from_bottom, prot_lvl}))
    else $error("Locked protection bits changed");
  status_write_cmd_clear_a: assert property (exec_status_write_cmd |=> !write_enable_latch)
    else $error("Latch survived status write");
  chip_guard_a: assert property (exec_ce && !ce_ok |=> !busy)
    else $error("Chip erase ran with protection set");
  busy_end_a: assert property (busy_last |=> !busy && !write_enable_latch)
    else $error("Busy end did not clear busy and latch");
  prot_block_a: assert property (exec_se && tgt_prot && !busy
      |=> !busy)
    else $error("Protected sector erase started");

  status_write_c: cover property (exec_status_write_cmd && !lock_on);
  program_c: cover property (arr_start && exec_pp);
  read_busy_c: cover property (busy && o_so_oe);
  hold_c: cover property (held ##1 !held && !cs_f);

endmodule : sfsp_flash_port

`default_nettype wire

//--- sfsp_host_model.sv
// SPI host model that drives the flash port pins in mode 0 or mode 3
`timescale 1ns/1ns
`default_nettype none
module sfsp_host_model (
  input wire logic i_clk_sys,
  input wire logic i_so,
  output logic o_sck,
  output logic o_si,
  output logic o_cs_n,
  output logic o_hold_n
);
  int pause_at = -1;
  initial begin
    o_sck = 1'b0;
    o_si = 1'b0;
    o_cs_n = 1'b1;
    o_hold_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : tick
  task automatic frame(input logic mode, input logic [7:0] q[$],
      output logic [7:0] rx);
    int nb;
    nb = 0;
    rx = 8'h00;
    o_sck <= mode;
    tick(4);
    o_cs_n <= 1'b0;
    tick(4);
    foreach (q[k]) begin
      for (int b = 7; b >= 0; b--) begin
        o_sck <= 1'b0;
        o_si <= q[k][b];
        tick(4);
        o_sck <= 1'b1;
        tick(4);
        rx = {rx[6:0], i_so};
        nb++;
        if (nb == pause_at) begin
          // Pause entered and left with clock low; stray clocks ignored
          o_sck <= 1'b0;
          tick(4);
          o_hold_n <= 1'b0;
          tick(4);
          repeat (3) begin
            o_sck <= 1'b1;
            tick(4);
            o_sck <= 1'b0;
            tick(4);
          end
          o_hold_n <= 1'b1;
          tick(4);
        end
      end
    end
    o_sck <= mode;
    tick(4);
    o_cs_n <= 1'b1;
    // Released data line must not look held
    o_si <= ~o_si;
    tick(10);
  endtask : frame
endmodule : sfsp_host_model
`default_nettype wire

//--- sfsp_flash_port_bench.sv
// Self-checking bench for the serial flash port against a host model
`timescale 1ns/1ns
`default_nettype none
module sfsp_flash_port_bench;
  logic clk, rst_n, sck, si, cs_n, wp_n, hold_n, so, so_oe;
  int fails = 0;
  int checks_done = 0;
  int seed = 50;
  int lvl = 0, bot = 0, lock = 0, write_enable_latch = 0;
  logic [7:0] q[$];
  logic [7:0] s;
  // Undriven line reads inverted so a missing enable shows
  wire so_line = so_oe ? so : ~so;
  sfsp_flash_port #(.PROG_CYCLES(24'h000258), .SECTOR_CYCLES(24'h000320),
    .BLOCK_CYCLES(24'h0003e8), .CHIP_CYCLES(24'h0004b0)) uut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_sck(sck), .i_si(si),
    .i_cs_n(cs_n), .i_wp_n(wp_n), .i_hold_n(hold_n), .o_so(so),
    .o_so_oe(so_oe));
  sfsp_host_model host (.i_clk_sys(clk), .i_so(so_line), .o_sck(sck),
    .o_si(si), .o_cs_n(cs_n), .o_hold_n(hold_n));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("fails=%0d checks_done=%0d", fails, checks_done);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  function automatic logic [7:0] stat(input logic b);
    return {lock[0], 1'b0, bot[0], lvl[2:0], write_enable_latch[0], b};
  endfunction : stat
  function automatic bit prot(input int blk);
    int n;
    n = (lvl < 3) ? lvl : (lvl == 3) ? 4 : (lvl == 5) ? 6 : (lvl == 6) ? 7 : 8;
    return bot ? (blk < n) : (blk >= 8 - n);
  endfunction : prot
  task automatic xfer(output logic [7:0] rx);
    int m;
    m = $random(seed);
    host.frame(m[0], q, rx);
  endtask : xfer
  task automatic rd_status(output logic [7:0] rx);
    q = {sfsp_pkg::OP_STATUS_READ, 8'h00};
    xfer(rx);
  endtask : rd_status
  task automatic op1(input logic [7:0] opc);
    logic [7:0] junk;
    q = {opc};
    xfer(junk);
  endtask : op1
  task automatic wr_stat(input logic [7:0] d);
    op1(sfsp_pkg::OP_WRITE_ENABLE);
    q = {sfsp_pkg::STATUS_WRITE_CMD, d};
    xfer(s);
    // lock refuses only with pin low
    if (!(wp_n === 1'b0 && lock == 1)) begin
      lvl = d[4:2];
      bot = d[5];
      lock = d[7];
    end
    write_enable_latch = 0;
  endtask : wr_stat
  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    conclude();
  end
  initial begin
    int r;
    int k;
    bit ok;
    logic [18:0] a;
    rst_n = 1'b0;
    wp_n = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_status(s);
    check(s, 8'h00);
    check({7'h00, so_oe}, 8'h00);
    host.pause_at = 3;
    op1(sfsp_pkg::OP_WRITE_ENABLE);
    host.pause_at = -1;
    write_enable_latch = 1;
    rd_status(s);
    check(s, stat(1'b0));
    op1(sfsp_pkg::OP_WRITE_DISABLE);
    write_enable_latch = 0;
    rd_status(s);
    check(s, stat(1'b0));
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      wp_n <= (i == 1) ? 1'b0 : r[8];
      wr_stat((i < 2) ? 8'hff : r[7:0]);
      rd_status(s);
      check(s, stat(1'b0));
    end
    wp_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      r = $random(seed);
      wr_stat((i == 3) ? 8'h00 : {2'h0, r[5:0]});
      k = (i < 5) ? i % 4 : r[9:8];
      a = r[28:10];
      op1(sfsp_pkg::OP_WRITE_ENABLE);
      q = {};
      q.push_back((k == 0) ? sfsp_pkg::OP_PAGE_PROGRAM :
        (k == 1) ? sfsp_pkg::OP_SECTOR_ERASE :
        (k == 2) ? sfsp_pkg::OP_BLOCK_ERASE : sfsp_pkg::OP_CHIP_ERASE);
      if (k != 3) begin
        q.push_back({5'h00, a[18:16]});
        q.push_back(a[15:8]);
        q.push_back(a[7:0]);
      end
      if (k == 0) begin
        repeat ((i == 0) ? 256 : 1 + r[31:30]) q.push_back(8'($random(seed)));
      end
      ok = (k == 3) ? (lvl == 0) : !prot(a[18:16]);
      xfer(s);
      write_enable_latch = ok;
      rd_status(s);
      check(s, stat(ok));
      op1(sfsp_pkg::OP_WRITE_ENABLE);
      rd_status(s);
      for (int p = 0; p < 40 && s[0] !== 1'b0; p++) begin
        rd_status(s);
      end
      // Latch set only when the enable arrived while idle
      write_enable_latch = !ok;
      check(s, stat(1'b0));
    end
    conclude();
  end
endmodule : sfsp_flash_port_bench
`default_nettype wire
